// ### design/flyback_cfg.svh
// constants of the flyback protection sequencer: offsets, fields, resets, times
// assumes a 100 MHz core clock; included by the design module
//
// What this block does
// - brown-out low stops drive pulses
// - no restart until line back in range
// - line ok clears brown-out, restart at start-up threshold
// - line low must persist 68 or 136 ms
// - feedback fold lowers frequency to 26 kHz floor
// - freeze peak setpoint, skip cycles below it
// - jitter active in normal and foldback modes
// - soft-start fixed at 8 ms
// - soft-start on every start and hiccup restart
// - fault pin upper trip latches off
// - fault pin lower trip disables switching
// - supply over-voltage stops pulses, hiccup or latch
// - peak limit sets overload flag, 64 ms timer
// - validated overload stops pulses, retries with soft-start
// - pulses off 1 s between retries
// - overload gone at retry resumes switching
// - option latches off on validated short
// - trickle current below inhibit, main current above
// - start-up source on until start-up threshold
// - wake bias raised above supply minimum
// - self-supply option holds supply between levels
// - fault pin latches after four drive clocks
// - fault comparator must stand 600 ns
// - lower fault trip ignored during soft-start
// - brown-out: source on at minimum, recheck at start-up
`ifndef FLYBACK_CFG_SVH
`define FLYBACK_CFG_SVH

`define CLK_MHZ 100
`define T_BO_US 68000
`define T_BO_LONG_US 136000
`define T_SS_US 8000
`define T_OCP_US 64000
`define T_AUTOREC_US 1000000
`define T_FAULT_MIN_NS 600
`define FAULT_CONFIRM 3'h4
`define F_NORM_KHZ 65
`define F_FOLD_KHZ 45
`define F_FLOOR_KHZ 26
`define MAX_DUTY_PCT 80

`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define CTRL_RESET 4'h1
`define CTRL_AUTOREC_OVP 0
`define CTRL_LATCH_SHORT 1
`define CTRL_SELF_SUPPLY 2
`define CTRL_LONG_BO 3

`endif

// ### design/flyback_pkg.sv
// types shared by the sequencer: states, comparator flags, outputs, bus request
// assumes flyback_cfg.svh sits beside it
package flyback_pkg;

    typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_RETRY, ST_BO_WAIT, ST_LATCH} seqState_t;

    typedef struct packed {
        logic lineLow;
        logic lineOk;
        logic faultUpper;
        logic faultLower;
        logic vccOvp;
        logic vccOn;
        logic vccMin;
        logic vccInhibit;
        logic vccReset;
        logic peakLimit;
        logic csTrip;
        logic fbFold;
        logic fbFloor;
        logic fbFreeze;
        logic fbSkip;
    } compFlags_t;

    typedef struct packed {
        logic gateDriveOut;
        logic startupSourceOn;
        logic startupMainCurrent;
        logic wakeBiasOn;
        logic linePowerOffsetOn;
        logic peakFreeze;
        logic softStartActive;
        logic otpBoost;
        logic [7:0] softLevel;
    } powerCtl_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmReq_t;

endpackage

// ### design/flyback_protection_sequencer.sv
// start, stop, restart and latch-off sequencer of a peak-current flyback controller
// assumes asynchronous comparator flags and an Avalon-MM master on mclk
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "flyback_cfg.svh"

module flyback_protection_sequencer #(
    parameter int BO_CYC = `T_BO_US * `CLK_MHZ,
    parameter int BO_LONG_CYC = `T_BO_LONG_US * `CLK_MHZ,
    parameter int SS_CYC = `T_SS_US * `CLK_MHZ,
    parameter int OCP_CYC = `T_OCP_US * `CLK_MHZ,
    parameter int AUTOREC_CYC = `T_AUTOREC_US * `CLK_MHZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // analog comparator flags
    input wire flyback_pkg::compFlags_t comp,
    // power stage controls
    output flyback_pkg::powerCtl_t ctl,
    // register bus
    input wire flyback_pkg::avmReq_t avm,
    output logic [31:0] readdata,
    output logic waitrequest
);
    import flyback_pkg::*;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int FLT_MIN = (`T_FAULT_MIN_NS * `CLK_MHZ + 999) / 1000;
    localparam logic [11:0] PER_NORM = 12'(1000 * `CLK_MHZ / `F_NORM_KHZ);
    localparam logic [11:0] PER_FOLD = 12'(1000 * `CLK_MHZ / `F_FOLD_KHZ);
    localparam logic [11:0] PER_FLOOR = 12'(1000 * `CLK_MHZ / `F_FLOOR_KHZ);
    localparam logic [11:0] MAX_ON = 12'(1000 * `CLK_MHZ / `F_NORM_KHZ * `MAX_DUTY_PCT / 100);
    localparam logic [6:0] FLT_MIN7 = 7'(FLT_MIN);
    localparam logic [26:0] BO_T = 27'(BO_CYC);
    localparam logic [26:0] BO_LONG_T = 27'(BO_LONG_CYC);
    localparam logic [26:0] SS_T = 27'(SS_CYC);
    localparam logic [26:0] OCP_T = 27'(OCP_CYC);
    localparam logic [26:0] AR_T = 27'(AUTOREC_CYC);
    localparam logic [26:0] SS_STEP = 27'(SS_CYC / 256);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        seqState_t st;
        compFlags_t s1;
        compFlags_t s2;
        compFlags_t prev;
        logic [3:0] ctrl;
        logic boLatch;
        logic ocpFlag;
        logic ocpHit;
        logic upVal;
        logic loVal;
        logic [2:0] fltCnt;
        logic [6:0] upCnt;
        logic [6:0] loCnt;
        logic [26:0] tmr;
        logic [26:0] boTmr;
        logic [26:0] ocpTmr;
        logic [26:0] ssDiv;
        logic [11:0] per;
        logic [3:0] jit;
        logic jitDown;
        powerCtl_t ctl;
        logic waitReq;
        logic [31:0] rdata;
    } seqRegs_t;

    seqRegs_t r;
    seqRegs_t n;
    compFlags_t f;
    logic vccOnRise;
    logic pulsing;
    logic periodStart;
    logic [11:0] perLen;
    logic [26:0] boLimit;

    assign f = r.s2;
    assign vccOnRise = r.s2.vccOn & ~r.prev.vccOn;
    assign pulsing = (r.st == ST_SOFT) || (r.st == ST_RUN);
    assign periodStart = (r.per == 12'h000);
    assign boLimit = r.ctrl[`CTRL_LONG_BO] ? BO_LONG_T : BO_T;

    assign ctl = r.ctl;
    assign readdata = r.rdata;
    assign waitrequest = r.waitReq;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        // two-stage synchronisers, then an edge reference
        n.s1 = comp;
        n.s2 = r.s1;
        n.prev = r.s2;

        // oscillator period with foldback and jitter in every mode
        if (f.fbFloor) begin
            perLen = PER_FLOOR + {8'h00, r.jit};
        end else if (f.fbFold) begin
            perLen = PER_FOLD + {8'h00, r.jit};
        end else begin
            perLen = PER_NORM + {8'h00, r.jit};
        end
        n.per = (r.per >= perLen - 12'h001) ? 12'h000 : r.per + 12'h001;
        if (periodStart) begin
            if (r.jitDown) begin
                n.jit = r.jit - 4'h1;
                n.jitDown = (r.jit != 4'h1);
            end else begin
                n.jit = r.jit + 4'h1;
                n.jitDown = (r.jit == 4'hE);
            end
        end

        // fault pin deglitch and confirmation over drive clocks
        n.upCnt = f.faultUpper ? ((r.upCnt == FLT_MIN7) ? r.upCnt : r.upCnt + 7'h01) : 7'h00;
        n.loCnt = (f.faultLower && r.st != ST_SOFT) ?
            ((r.loCnt == FLT_MIN7) ? r.loCnt : r.loCnt + 7'h01) : 7'h00;
        // a level that stays active re-validates every period, so it can be confirmed
        if (r.upCnt >= FLT_MIN7 - 7'h01) begin
            n.upVal = 1'b1;
        end
        if (r.loCnt >= FLT_MIN7 - 7'h01) begin
            n.loVal = 1'b1;
        end

        // overload flag follows the peak limit, one period at a time
        if (f.peakLimit) begin
            n.ocpHit = 1'b1;
        end
        n.ocpTmr = (r.ocpFlag && pulsing) ? r.ocpTmr + 27'h1 : 27'h0;

        // brown-out blanking timer
        n.boTmr = (f.lineLow && pulsing) ? r.boTmr + 27'h1 : 27'h0;

        if (periodStart) begin
            n.fltCnt = (r.upVal || r.loVal) ? r.fltCnt + 3'h1 : 3'h0;
            n.upVal = 1'b0;
            n.loVal = 1'b0;
            n.ocpFlag = r.ocpHit || f.peakLimit;
            n.ocpHit = 1'b0;
        end

        // sequencer
        case (r.st)
            ST_OFF: begin
                if (vccOnRise) begin
                    n.st = f.lineOk ? ST_SOFT : ST_BO_WAIT;
                    n.boLatch = ~f.lineOk;
                    n.tmr = 27'h0;
                end
            end
            ST_SOFT, ST_RUN: begin
                if (r.st == ST_SOFT) begin
                    n.tmr = r.tmr + 27'h1;
                    n.ssDiv = (r.ssDiv == SS_STEP - 27'h1) ? 27'h0 : r.ssDiv + 27'h1;
                    if (r.ssDiv == SS_STEP - 27'h1 && r.ctl.softLevel != 8'hFF) begin
                        n.ctl.softLevel = r.ctl.softLevel + 8'h01;
                    end
                    if (r.tmr == SS_T - 27'h1) begin
                        n.st = ST_RUN;
                        n.ctl.softLevel = 8'hFF;
                    end
                end
                if (f.vccOvp) begin
                    n.st = r.ctrl[`CTRL_AUTOREC_OVP] ? ST_RETRY : ST_LATCH;
                    n.tmr = 27'h0;
                end else if (periodStart && r.fltCnt == `FAULT_CONFIRM - 3'h1 &&
                        (r.upVal || r.loVal)) begin
                    n.st = ST_LATCH;
                end else if (r.ocpTmr == OCP_T - 27'h1) begin
                    n.st = r.ctrl[`CTRL_LATCH_SHORT] ? ST_LATCH : ST_RETRY;
                    n.tmr = 27'h0;
                end else if (r.boTmr == boLimit - 27'h1) begin
                    n.st = ST_BO_WAIT;
                    n.boLatch = 1'b1;
                end
            end
            ST_RETRY: begin
                n.tmr = r.tmr + 27'h1;
                if (r.tmr == AR_T - 27'h1) begin
                    n.st = ST_SOFT;
                    n.tmr = 27'h0;
                end
            end
            ST_BO_WAIT: begin
                if (vccOnRise && f.lineOk) begin
                    n.st = ST_SOFT;
                    n.boLatch = 1'b0;
                    n.tmr = 27'h0;
                end
            end
            ST_LATCH: begin
                n.st = ST_LATCH;
            end
            default: begin
                n.st = ST_OFF;
            end
        endcase
        if (f.vccReset) begin
            n.st = ST_OFF;
            n.boLatch = 1'b0;
        end
        if (n.st == ST_SOFT && r.st != ST_SOFT) begin
            n.tmr = 27'h0;
            n.ssDiv = 27'h0;
            n.ctl.softLevel = 8'h00;
            n.fltCnt = 3'h0;
            n.ocpFlag = 1'b0;
            n.ocpHit = 1'b0;
        end
        if (n.st != ST_SOFT && n.st != ST_RUN) begin
            n.fltCnt = 3'h0;
        end

        // gate drive: starts on the period edge, ends on current trip or max on-time
        if (n.st != ST_SOFT && n.st != ST_RUN) begin
            n.ctl.gateDriveOut = 1'b0;
        end else if (periodStart && !f.fbSkip) begin
            n.ctl.gateDriveOut = 1'b1;
        end else if (f.csTrip || f.peakLimit || r.per >= MAX_ON) begin
            n.ctl.gateDriveOut = 1'b0;
        end

        // start-up source and bias
        if (n.st == ST_OFF) begin
            n.ctl.startupSourceOn = ~f.vccOn;
        end else if (pulsing && !r.ctrl[`CTRL_SELF_SUPPLY]) begin
            n.ctl.startupSourceOn = 1'b0;
        end else if (!f.vccMin) begin
            n.ctl.startupSourceOn = 1'b1;
        end else if (f.vccOn) begin
            n.ctl.startupSourceOn = 1'b0;
        end
        n.ctl.startupMainCurrent = f.vccInhibit;
        n.ctl.wakeBiasOn = f.vccMin;
        n.ctl.linePowerOffsetOn = ~f.fbFold;
        n.ctl.peakFreeze = f.fbFreeze;
        n.ctl.softStartActive = (n.st == ST_SOFT);
        n.ctl.otpBoost = (n.st == ST_SOFT);

        // bus slave: one wait cycle, then a single low cycle
        n.waitReq = 1'b1;
        if ((avm.read || avm.write) && r.waitReq) begin
            n.waitReq = 1'b0;
            n.rdata = 32'h0000_0000;
            if (avm.read && avm.address == `OFS_CTRL) begin
                n.rdata = {28'h000_0000, r.ctrl};
            end else if (avm.read && avm.address == `OFS_STATUS) begin
                n.rdata = {16'h0000, 5'h00, r.fltCnt, r.ocpFlag, r.boLatch,
                    r.ctl.gateDriveOut, r.ctl.startupSourceOn, 1'b0, r.st};
            end
            if (avm.write && avm.address == `OFS_CTRL) begin
                n.ctrl = avm.writedata[3:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.waitReq <= 1'b1;
            r.ctrl <= `CTRL_RESET;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_retry_done;
        r.st == ST_RETRY && r.tmr == AR_T - 27'h1 && !f.vccReset;
    endsequence

    sequence s_soft_entered;
        r.st == ST_SOFT && r.tmr == 27'h0 && r.ctl.softLevel == 8'h00;
    endsequence

    property p_no_drive_when_stopped;
        !(r.st == ST_SOFT || r.st == ST_RUN) |-> !r.ctl.gateDriveOut;
    endproperty
    a_no_drive_when_stopped: assert property (p_no_drive_when_stopped)
        else $error("drive pulse outside soft-start or run");

    property p_bo_hold;
        r.st == ST_BO_WAIT && !(vccOnRise && f.lineOk) && !f.vccReset |=> r.st == ST_BO_WAIT;
    endproperty
    a_bo_hold: assert property (p_bo_hold)
        else $error("left brown-out wait without line ok at start-up");

    property p_bo_recover;
        r.st == ST_BO_WAIT && vccOnRise && f.lineOk && !f.vccReset
            |=> s_soft_entered ##0 !r.boLatch;
    endproperty
    a_bo_recover: assert property (p_bo_recover)
        else $error("brown-out recovery did not restart with soft-start");

    property p_ovp_stop;
        pulsing && f.vccOvp && !f.vccReset
            |=> !r.ctl.gateDriveOut && (r.st == ST_RETRY || r.st == ST_LATCH);
    endproperty
    a_ovp_stop: assert property (p_ovp_stop)
        else $error("supply over-voltage did not stop pulses at once");

    property p_retry_restart;
        s_retry_done |=> s_soft_entered;
    endproperty
    a_retry_restart: assert property (p_retry_restart)
        else $error("retry off time did not end in soft-start");

    property p_fault_latch;
        pulsing && periodStart && r.fltCnt == 3'h3 && (r.upVal || r.loVal) && !f.vccReset
            |=> r.st == ST_LATCH [*2];
    endproperty
    a_fault_latch: assert property (p_fault_latch)
        else $error("fourth confirmed fault pin event did not latch");

    property p_otp_ignored;
        r.st == ST_SOFT |-> r.loCnt == 7'h00 && !$rose(r.loVal);
    endproperty
    a_otp_ignored: assert property (p_otp_ignored)
        else $error("lower fault comparator counted during soft-start");

    property p_fault_min_width;
        $rose(r.upVal) |-> $past(r.upCnt) >= FLT_MIN7 - 7'h01;
    endproperty
    a_fault_min_width: assert property (p_fault_min_width)
        else $error("fault event validated before minimum width");

    property p_ocp_validate;
        pulsing && r.ocpTmr == OCP_T - 27'h1 && !f.vccOvp && !f.vccReset && !(periodStart &&
            r.fltCnt == 3'h3 && (r.upVal || r.loVal))
            |=> r.st == (r.ctrl[`CTRL_LATCH_SHORT] ? ST_LATCH : ST_RETRY) ##0 !r.ctl.gateDriveOut;
    endproperty
    a_ocp_validate: assert property (p_ocp_validate)
        else $error("validated overload did not stop pulses");

    property p_bus_single_ack;
        !r.waitReq |=> r.waitReq;
    endproperty
    a_bus_single_ack: assert property (p_bus_single_ack)
        else $error("waitrequest low for more than one cycle");

endmodule

// ### verif/power_stage_model.sv
// power switch and current-sense comparators facing the sequencer
// assumes gate drive from the sequencer on the same clock
`timescale 1ns/1ps

module power_stage_model #(
    parameter int RAMP_CYC = 200
) (
    // clock
    input wire logic mclk,
    // scenario control
    input wire logic overload,
    // switch side
    input wire logic gateDriveOut,
    output logic csTrip,
    output logic peakLimit
);
    int ramp = 0;

    // ----------------------------------------------------------------
    // primary current ramp, reset whenever the switch is off
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!gateDriveOut) begin
            ramp <= 0;
        end else begin
            ramp <= ramp + 1;
        end
    end

    // a shorted output ramps four times faster and meets the peak limit in the same cycle as the current trip
    assign csTrip = gateDriveOut && (ramp >= (overload ? RAMP_CYC / 4 : RAMP_CYC));
    assign peakLimit = gateDriveOut && overload && (ramp >= RAMP_CYC / 4);
endmodule

// ### verif/flyback_protection_sequencer_bench.sv
// self-checking bench of the flyback protection sequencer
// assumes the design package, the power stage model and shortened timers
`timescale 1ns/1ps

module flyback_protection_sequencer_bench;
    import flyback_pkg::*;

    localparam int SS = 2560;
    localparam int AR = 3000;
    typedef struct {
        compFlags_t f;
        logic [2:0] exp;
        logic [2:0] mask;
    } row_t;
    row_t rows[4];
    logic mclk;
    logic reset;
    compFlags_t flags;
    compFlags_t comp;
    powerCtl_t ctl;
    avmReq_t avm;
    logic [31:0] readdata;
    logic waitrequest;
    logic overload;
    logic csTrip;
    logic peakLimit;
    logic [31:0] rd;
    int nFail = 0;
    int numChecks = 0;

    flyback_protection_sequencer #(.BO_CYC(2000), .BO_LONG_CYC(4000), .SS_CYC(SS),
        .OCP_CYC(1500), .AUTOREC_CYC(AR)) i_flyback_protection_sequencer (
        .mclk(mclk), .reset(reset), .comp(comp), .ctl(ctl), .avm(avm),
        .readdata(readdata), .waitrequest(waitrequest));
    power_stage_model i_power_stage_model (.mclk(mclk), .overload(overload),
        .gateDriveOut(ctl.gateDriveOut), .csTrip(csTrip), .peakLimit(peakLimit));

    always_comb begin
        comp = flags;
        comp.csTrip = csTrip;
        comp.peakLimit = peakLimit;
    end

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp, input string what);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // waits for waitrequest low, read data taken at the closing edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avm <= '{address: a, read: !wr, write: wr, writedata: d};
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        avm.read <= 1'b0;
        avm.write <= 1'b0;
    endtask

    task automatic wait_state(input logic [2:0] s, input int polls, input string what);
        for (int i = 0; i < polls; i++) begin
            bus(1'b0, 4'h4, 32'h0);
            if (rd[2:0] === s) break;
        end
        chk_word({29'h0, rd[2:0]}, {29'h0, s}, what);
    endtask

    task automatic count_pulses(input int n, output int cnt);
        logic last;
        last = ctl.gateDriveOut;
        cnt = 0;
        repeat (n) begin
            @(negedge mclk);
            if (ctl.gateDriveOut === 1'b1 && last !== 1'b1) cnt++;
            last = ctl.gateDriveOut;
        end
        @(posedge mclk);
    endtask

    task automatic power_up();
        @(posedge mclk);
        flags <= 15'h0040;
        repeat (8) @(posedge mclk);
        flags <= 15'h0180;
        repeat (8) @(posedge mclk);
        flags <= 15'h2380;
        wait_state(3'h1, 50, "soft-start state");
    endtask

    initial begin
        repeat (95000) @(posedge mclk);
        nFail++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int cnt;
        reset = 1'b1;
        flags = '0;
        overload = 1'b0;
        avm = '0;
        rows[0] = '{15'h0000, 3'h4, 3'h7};
        rows[1] = '{15'h0080, 3'h6, 3'h7};
        rows[2] = '{15'h0180, 3'h7, 3'h7};
        rows[3] = '{15'h2380, 3'h0, 3'h4};
        repeat (16) @(posedge mclk);
        chk_word({16'h0, ctl}, 32'h0, "outputs in reset");
        chk_pin(waitrequest, 1'b1, "waitrequest in reset");
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            flags <= rows[i].f;
            repeat (6) @(posedge mclk);
            @(negedge mclk);
            chk_word({29'h0, {ctl.startupSourceOn, ctl.startupMainCurrent, ctl.wakeBiasOn}
                & rows[i].mask}, {29'h0, rows[i].exp}, "start-up source");
        end
        wait_state(3'h1, 20, "soft-start after start-up");
        chk_pin(ctl.softStartActive, 1'b1, "soft-start flag");
        flags.faultLower <= 1'b1;
        repeat (SS - 400) @(posedge mclk);
        flags.faultLower <= 1'b0;
        wait_state(3'h1, 1, "still in soft-start");
        wait_state(3'h2, 200, "run after soft-start");
        bus(1'b0, 4'h0, 32'h0);
        chk_word(rd, 32'h1, "control reset value");
        bus(1'b1, 4'h0, 32'hA);
        bus(1'b0, 4'h0, 32'h0);
        chk_word(rd, 32'hA, "control write");
        bus(1'b1, 4'h8, 32'hF);
        bus(1'b0, 4'h8, 32'h0);
        chk_word(rd, 32'h0, "unmapped read");
        bus(1'b1, 4'h4, 32'hFF);
        bus(1'b1, 4'h0, 32'h1);
        wait_state(3'h2, 1, "status write ignored");
        count_pulses(3200, cnt);
        chk_pin(cnt != 0, 1'b1, "pulses while running");
        repeat (5) begin
            flags.faultUpper <= 1'b1;
            repeat (30) @(posedge mclk);
            flags.faultUpper <= 1'b0;
            repeat (1500) @(posedge mclk);
        end
        wait_state(3'h2, 1, "short fault pulses ignored");
        flags.faultUpper <= 1'b1;
        repeat (3000) @(posedge mclk);
        wait_state(3'h2, 1, "fault not yet confirmed");
        wait_state(3'h5, 2000, "fault latch");
        flags.faultUpper <= 1'b0;
        count_pulses(1000, cnt);
        chk_pin(cnt != 0, 1'b0, "no pulses when latched");
        wait_state(3'h5, 1, "latch persists");
        power_up();
        wait_state(3'h2, 1000, "run after restart");
        flags.lineLow <= 1'b1;
        flags.lineOk <= 1'b0;
        repeat (1700) @(posedge mclk);
        wait_state(3'h2, 1, "brown-out blanking");
        wait_state(3'h4, 200, "brown-out stop");
        count_pulses(1000, cnt);
        chk_pin(cnt != 0, 1'b0, "no pulses in brown-out");
        flags.lineLow <= 1'b0;
        flags.lineOk <= 1'b1;
        repeat (500) @(posedge mclk);
        wait_state(3'h4, 1, "no restart before start-up event");
        flags.vccOn <= 1'b0;
        repeat (8) @(posedge mclk);
        flags.vccOn <= 1'b1;
        wait_state(3'h1, 20, "restart at start-up event");
        wait_state(3'h2, 1000, "run after brown-out");
        overload <= 1'b1;
        for (int i = 0; i < 1200; i++) begin
            bus(1'b0, 4'h4, 32'h0);
            if (rd[7] === 1'b1) break;
        end
        chk_pin(rd[7], 1'b1, "overload flag");
        wait_state(3'h3, 800, "overload retry");
        count_pulses(AR - 600, cnt);
        chk_pin(cnt != 0, 1'b0, "pulses off between retries");
        wait_state(3'h1, 300, "retry soft-start");
        overload <= 1'b0;
        wait_state(3'h2, 1000, "resume after overload");
        bus(1'b1, 4'h0, 32'h3);
        overload <= 1'b1;
        wait_state(3'h5, 2000, "latch on short");
        overload <= 1'b0;
        bus(1'b1, 4'h0, 32'h1);
        power_up();
        wait_state(3'h2, 1000, "run after short latch");
        flags.fbSkip <= 1'b1;
        repeat (10) @(posedge mclk);
        count_pulses(3200, cnt);
        chk_pin(cnt != 0, 1'b0, "skip holds pulses");
        flags.fbSkip <= 1'b0;
        count_pulses(3200, cnt);
        chk_pin(cnt != 0, 1'b1, "pulses after skip");
        flags.fbFold <= 1'b1;
        flags.fbFreeze <= 1'b1;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk_pin(ctl.linePowerOffsetOn, 1'b0, "offset off in foldback");
        chk_pin(ctl.peakFreeze, 1'b1, "peak setpoint frozen");
        bus(1'b1, 4'h0, 32'h0);
        flags.vccOvp <= 1'b1;
        wait_state(3'h5, 50, "supply over-voltage latch");
        chk_pin(ctl.gateDriveOut, 1'b0, "gate off on over-voltage");
        give_verdict();
    end
endmodule
